// ### core/host_port_pkg.sv
package host_port_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int ADDR_W = 7;            // Word address bits [7:1]
  localparam int LOW_ADDR_W = 2;        // Bits still used in FIFO-direct mode
  localparam int CSR_IDX_W = 5;         // Index field for status/control reads
  localparam int BURST_MAX_32 = 8;
  localparam int BURST_MAX_16 = 16;
  localparam int RX_FIFO_DEPTH = 8;

  // ----------------------------------------
  // Host timing, for reference
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_CSL_NS = 32;
  localparam int T_CYCLE_NS = 45;
  localparam int T_CSH_NS = 13;
  localparam int T_INFO_WAIT_NS = 135;
  localparam int T_CSL_CYC = (T_CSL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_CYCLE_CYC = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_CSH_CYC = (T_CSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_INFO_WAIT_CYC = (T_INFO_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Read source selection
  // ----------------------------------------
  localparam logic [1:0] SRC_CSR = 2'h0;
  localparam logic [1:0] SRC_RX_DATA = 2'h1;
  localparam logic [1:0] SRC_RX_STS = 2'h2;
  localparam logic [1:0] SRC_TX_STS = 2'h3;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 7'h00;

  // ----------------------------------------
  // Port state
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } port_state_t;

  // Decoded host request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic fifo_sel;
    logic [DATA_W-1:0] data;
  } host_req_t;

  // Write handed to the core
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wr_cmd_t;

endpackage

// ### core/rx_word_fifo.sv
`timescale 1ns/10ps
module rx_word_fifo import host_port_pkg::*; #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,               // Clock
  input wire logic rst_n_i,             // Synchronised reset
  input wire logic in_valid_i,          // Write request
  output logic in_ready_o,              // Not full
  input wire logic [WIDTH-1:0] in_data_i, // Write word
  output logic out_valid_o,             // Not empty
  input wire logic out_ready_i,         // Pop request
  output logic [WIDTH-1:0] out_data_o   // Head word, registered
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] count_ff;
  logic [WIDTH-1:0] head_ff;
  logic push;
  logic pop;
  logic [PW-1:0] nxt_rd_ptr;

  // ----------------------------------------
  // Flags and strobes
  // ----------------------------------------
  assign in_ready_o = (count_ff != (PW+1)'(DEPTH)); // Full at DEPTH words
  assign out_valid_o = (count_ff != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;
  assign nxt_rd_ptr = (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
  assign out_data_o = head_ff;

  // Storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= nxt_rd_ptr;
      end
      count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Registered head word, follows read pointer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      head_ff <= '0;
    end else if (push && (count_ff == '0 || (pop && count_ff == (PW+1)'(1)))) begin
      head_ff <= in_data_i;
    end else if (pop) begin
      head_ff <= mem_ff[nxt_rd_ptr];
    end
  end
endmodule

// ### core/csr_snapshot.sv
`timescale 1ns/10ps
module csr_snapshot import host_port_pkg::*; #(
  parameter int WIDTH = 32
) (
  input wire logic clk_i,               // Clock
  input wire logic rst_n_i,             // Synchronised reset
  input wire logic capture_i,           // Read beat pulse, at cycle start and at each burst address step
  input wire logic [WIDTH-1:0] live_i,  // Live register value
  output logic [WIDTH-1:0] held_o       // Value frozen at capture
);
  logic [WIDTH-1:0] held_ff;

  // Freeze the value at the start of a read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held_ff <= '0;
    end else if (capture_i) begin
      held_ff <= live_i;
    end
  end
  assign held_o = held_ff;
endmodule

// ### core/sram_like_host_bus_port.sv
`timescale 1ns/10ps
// Contract
// - A cycle starts when select and a strobe are both low and ends when either rises.
// - Counter registers are captured at the start of a read cycle.
// - Single reads return registers, receive data words, or receive/transmit status.
// - Every write is one cycle framed by select and the write strobe.
// - In 16-bit mode the upper data half is never driven on reads.
// - In 16-bit mode the upper data half is ignored on writes.
// - A normal burst holds the strobes for up to 8 word or 16 half-word reads.
// - With FIFO-direct select high a read ignores upper address and returns receive data.
// - FIFO-direct reads still use the two low address bits and ignore the five above.
// - FIFO-direct bursts are unlimited and pop successive receive words.
module sram_like_host_bus_port import host_port_pkg::*; #(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  input wire logic sys_clk_i,                      // System clock, 125 MHz
  input wire logic nrst_i,                         // Async reset, active low
  input wire logic chip_select_low_i,              // Chip select, active low
  input wire logic read_strobe_low_i,              // Read strobe, active low
  input wire logic write_strobe_low_i,             // Write strobe, active low
  input wire logic [ADDR_W-1:0] addr_i,            // Word address bits [7:1]
  input wire logic fifo_sel_i,                     // FIFO-direct select
  input wire logic bus16_i,                        // Bus configured 16 bits wide
  input wire logic [DATA_W-1:0] data_i,            // Data bus input
  output logic [DATA_W-1:0] data_o,                // Data bus output
  output logic data_lo_oe_o,                       // Drive enable, low half
  output logic data_hi_oe_o,                       // Drive enable, high half
  input wire logic rx_in_valid_i,                  // Receive word valid
  output logic rx_in_ready_o,                      // Receive buffer can accept
  input wire logic [DATA_W-1:0] rx_in_data_i,      // Receive word from core
  input wire logic [DATA_W-1:0] csr_live_i,        // Live register value
  output logic [CSR_IDX_W-1:0] csr_idx_o,          // Register index requested
  input wire logic [DATA_W-1:0] rx_sts_i,          // Receive status head
  output logic rx_sts_pop_o,                       // Receive status popped
  input wire logic [DATA_W-1:0] tx_sts_i,          // Transmit status head
  output logic tx_sts_pop_o,                       // Transmit status popped
  input wire logic [CSR_IDX_W-1:0] rx_data_idx_i,  // Index mapped to receive data port
  input wire logic [CSR_IDX_W-1:0] rx_sts_idx_i,   // Index mapped to receive status port
  input wire logic [CSR_IDX_W-1:0] tx_sts_idx_i,   // Index mapped to transmit status port
  output logic wr_valid_o,                         // Write pulse to core
  output wr_cmd_t wr_cmd_o,                        // Write address and data
  output logic burst_over_o                        // Normal burst exceeded its limit
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------
  // Cycle framing
  // ----------------------------------------
  logic rd_active;
  logic wr_active;
  logic rd_seen;
  logic wr_seen;
  logic rd_start;
  logic wr_start;
  logic wr_end;
  port_state_t state_ff;
  port_state_t nxt_state;
  host_req_t req;

  // Both select and strobe low frame the cycle, in any order
  assign rd_active = !chip_select_low_i && !read_strobe_low_i;
  assign wr_active = !chip_select_low_i && !write_strobe_low_i && !rd_active;
  assign rd_start = rd_active && !rd_seen;
  assign wr_start = wr_active && !wr_seen;
  assign wr_end = !wr_active && wr_seen;
  assign req = '{addr: addr_i, fifo_sel: fifo_sel_i, data: data_i};

  // ----------------------------------------
  // Framing state
  // ----------------------------------------
  // Which cycle the bus held at the last edge
  assign rd_seen = (state_ff == ST_READ);
  assign wr_seen = (state_ff == ST_WRITE);

  // Next state; a read that shows up wins over a write
  always_comb begin
    nxt_state = ST_IDLE;
    case (state_ff)
      ST_IDLE, ST_READ, ST_WRITE: begin
        if (rd_active) begin
          nxt_state = ST_READ;
        end else if (wr_active) begin
          nxt_state = ST_WRITE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic [CSR_IDX_W-1:0] csr_idx;
  logic [LOW_ADDR_W-1:0] low_addr;
  logic [1:0] src;
  logic addr_step;
  logic [ADDR_W-1:0] addr_ff;

  // FIFO-direct ignores the five upper bits, keeps the two low ones
  assign low_addr = req.addr[LOW_ADDR_W-1:0];
  assign csr_idx = req.addr[ADDR_W-1:LOW_ADDR_W];
  assign src = req.fifo_sel ? SRC_RX_DATA :
               (csr_idx == rx_data_idx_i) ? SRC_RX_DATA :
               (csr_idx == rx_sts_idx_i) ? SRC_RX_STS :
               (csr_idx == tx_sts_idx_i) ? SRC_TX_STS : SRC_CSR;
  // A new beat in a burst is marked by an address change (direct mode: low bits only)
  assign addr_step = rd_active && rd_seen &&
                     (req.fifo_sel ? (low_addr != addr_ff[LOW_ADDR_W-1:0])
                                   : (req.addr != addr_ff));
  assign csr_idx_o = req.fifo_sel ? '0 : csr_idx;

  // ----------------------------------------
  // Read beats
  // ----------------------------------------
  logic beat;
  logic [DATA_W-1:0] rd_word;
  logic rx_out_valid;
  logic [DATA_W-1:0] rx_head;
  logic rx_pop;
  logic [4:0] beat_cnt_ff;
  logic burst_over_ff;
  logic [DATA_W-1:0] nxt_rd_data;
  logic [4:0] beat_limit;
  logic limit_hit;

  // Pops fire once, on the beat that takes the word
  assign beat = rd_start || addr_step;
  assign rx_pop = beat && (src == SRC_RX_DATA);
  assign rx_sts_pop_o = beat && (src == SRC_RX_STS);
  assign tx_sts_pop_o = beat && (src == SRC_TX_STS);

  // ----------------------------------------
  // Read word hold
  // ----------------------------------------
  // Selected word frozen at the beat, so counters read as of the start
  csr_snapshot #(
    .WIDTH(DATA_W)
  ) u_snap (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n_ff),
    .capture_i(beat),
    .live_i(nxt_rd_data),
    .held_o(rd_word)
  );

  rx_word_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n_ff),
    .in_valid_i(rx_in_valid_i),
    .in_ready_o(rx_in_ready_o),
    .in_data_i(rx_in_data_i),
    .out_valid_o(rx_out_valid),
    .out_ready_i(rx_pop),
    .out_data_o(rx_head)
  );

  // Source select; empty receive FIFO reads as zero
  assign nxt_rd_data = (src == SRC_RX_DATA) ? (rx_out_valid ? rx_head : DATA_ZERO) :
                       (src == SRC_RX_STS) ? rx_sts_i :
                       (src == SRC_TX_STS) ? tx_sts_i : csr_live_i;

  // ----------------------------------------
  // Beat address
  // ----------------------------------------
  // Address of the last beat, for step detection
  always_ff @(posedge sys_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      addr_ff <= ADDR_ZERO;
    end else if (beat) begin
      addr_ff <= req.addr;
    end
  end

  // ----------------------------------------
  // Normal burst limit
  // ----------------------------------------
  // Beat limit of a normal burst for the configured width
  assign beat_limit = bus16_i ? 5'(BURST_MAX_16) : 5'(BURST_MAX_32);
  assign limit_hit = beat_cnt_ff >= beat_limit;

  // Beats taken in the current normal burst
  always_ff @(posedge sys_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      beat_cnt_ff <= '0;
    end else if (rd_start) begin
      beat_cnt_ff <= 5'h01;
    end else if (addr_step && !req.fifo_sel) begin
      beat_cnt_ff <= beat_cnt_ff + 5'h01;
    end
  end

  // Overrun flag, cleared by the next read start
  always_ff @(posedge sys_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      burst_over_ff <= 1'b0;
    end else if (rd_start) begin
      burst_over_ff <= 1'b0;
    end else if (addr_step && !req.fifo_sel && limit_hit) begin
      burst_over_ff <= 1'b1;
    end
  end
  assign burst_over_o = burst_over_ff;

  // ----------------------------------------
  // Data bus drive
  // ----------------------------------------
  logic rd_valid_ff;

  // Data is presented from the cycle after the beat is taken
  always_ff @(posedge sys_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_active;
    end
  end

  assign data_o = rd_word;
  assign data_lo_oe_o = rd_active && rd_valid_ff;
  assign data_hi_oe_o = rd_active && rd_valid_ff && !bus16_i;

  // ----------------------------------------
  // Write capture
  // ----------------------------------------
  logic wr_valid_ff;
  logic [ADDR_W-1:0] wr_addr_ff;
  logic [DATA_W-1:0] wr_data_ff;
  logic [DATA_W-1:0] wr_data;

  // Upper half ignored on 16-bit writes
  assign wr_data = bus16_i ? {{(DATA_W-HALF_W){1'b0}}, req.data[HALF_W-1:0]}
                           : req.data;

  // ----------------------------------------
  // Write command registers
  // ----------------------------------------
  // Single write pulse, one cycle after the frame closes
  always_ff @(posedge sys_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wr_valid_ff <= 1'b0;
    end else begin
      wr_valid_ff <= wr_end;
    end
  end

  // Address taken when the frame opens
  always_ff @(posedge sys_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wr_addr_ff <= ADDR_ZERO;
    end else if (wr_start) begin
      wr_addr_ff <= req.addr;
    end
  end

  // Data resampled while the frame holds; the last sample stands
  always_ff @(posedge sys_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wr_data_ff <= DATA_ZERO;
    end else if (wr_active) begin
      wr_data_ff <= wr_data;
    end
  end
  assign wr_valid_o = wr_valid_ff;
  assign wr_cmd_o = '{addr: wr_addr_ff, data: wr_data_ff};
endmodule

// ### tb/host_port_chk.sv
`timescale 1ns/10ps
module host_port_chk import host_port_pkg::*; (
  input wire logic sys_clk_i, // Clock
  input wire logic nrst_i, // Reset, active low
  input wire logic chip_select_low_i, // Select
  input wire logic read_strobe_low_i, // Read strobe
  input wire logic write_strobe_low_i, // Write strobe
  input wire logic [ADDR_W-1:0] addr_i, // Word address
  input wire logic fifo_sel_i, // Direct select
  input wire logic bus16_i, // Narrow bus
  input wire logic data_lo_oe_o, // Low half enable
  input wire logic data_hi_oe_o, // High half enable
  input wire logic [CSR_IDX_W-1:0] csr_idx_o, // Register index
  input wire logic rx_sts_pop_o, // Receive status pop
  input wire logic tx_sts_pop_o, // Transmit status pop
  input wire logic [CSR_IDX_W-1:0] rx_sts_idx_i, // Receive status index
  input wire logic wr_valid_o, // Write pulse
  input wire wr_cmd_t wr_cmd_o // Write command
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Cycle activity and start of a read
  logic rd_act, wr_act, rd_q, beat;
  assign rd_act = !chip_select_low_i && !read_strobe_low_i;
  assign wr_act = !chip_select_low_i && !write_strobe_low_i;
  assign beat = rd_act && !rd_q;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_q <= 1'h0;
    end else begin
      rd_q <= rd_act;
    end
  end

  // Write frame and its completion pulse
  sequence s_wr_frame;
    wr_act ##1 !wr_act;
  endsequence
  sequence s_wr_pulse;
    wr_valid_o ##1 !wr_valid_o;
  endsequence

  a_bus_idle: assert property (
    !rd_act |-> !data_lo_oe_o && !data_hi_oe_o)
    else $error("data bus driven outside a read");
  a_read_drive: assert property (
    rd_act && rd_q |-> data_lo_oe_o && data_hi_oe_o == !bus16_i)
    else $error("read halves not driven as configured");
  a_wr_pulse: assert property (
    s_wr_frame |-> ##1 s_wr_pulse)
    else $error("write frame gave no single pulse");
  a_wr_single: assert property (
    wr_valid_o |-> !$past(wr_act) && $past(wr_act, 2))
    else $error("write pulse without a closed frame");
  a_wr_upper: assert property (
    wr_valid_o && bus16_i |-> wr_cmd_o.data[31:16] == 16'h0000)
    else $error("upper half kept on narrow write");
  a_direct_idx: assert property (
    rd_act && fifo_sel_i |-> csr_idx_o == 5'h00)
    else $error("upper address decoded in direct mode");
  a_sts_pop: assert property (
    beat && !fifo_sel_i && addr_i[6:2] == rx_sts_idx_i |-> rx_sts_pop_o)
    else $error("status read did not pop");
  a_pop_read: assert property (
    rx_sts_pop_o || tx_sts_pop_o |-> rd_act && !fifo_sel_i)
    else $error("status popped outside a status read");
endmodule

bind sram_like_host_bus_port host_port_chk chk (.sys_clk_i, .nrst_i, .chip_select_low_i,
  .read_strobe_low_i, .write_strobe_low_i, .addr_i, .fifo_sel_i, .bus16_i, .data_lo_oe_o,
  .data_hi_oe_o, .csr_idx_o, .rx_sts_pop_o, .tx_sts_pop_o, .rx_sts_idx_i, .wr_valid_o,
  .wr_cmd_o);

// ### tb/host_bus_model.sv
`timescale 1ns/10ps
module host_bus_model import host_port_pkg::*; (
  input wire logic clk_i, // Clock
  input wire logic [DATA_W-1:0] bus_i, // Resolved data bus
  output logic cs_low_o, // Select, active low
  output logic rd_low_o, // Read strobe, active low
  output logic wr_low_o, // Write strobe, active low
  output logic [ADDR_W-1:0] addr_o, // Word address
  output logic fsel_o, // Direct select
  output logic [DATA_W-1:0] data_o // Host side of data bus
);
  logic [DATA_W-1:0] q [0:19]; // Captured beats

  // Idle bus at time zero
  initial begin
    {cs_low_o, rd_low_o, wr_low_o} = 3'h7;
    {addr_o, fsel_o} = 8'h00;
    data_o = 32'h5A5A_5A5A;
  end

  // Release, then stay idle for the deassertion time
  task automatic end_cyc();
    {cs_low_o, rd_low_o, wr_low_o} <= 3'h7;
    data_o <= ~data_o;
    repeat (T_CSH_CYC) @(posedge clk_i);
  endtask

  // Read beats under one strobe, address stepped once per cycle time
  task automatic burst(input logic [ADDR_W-1:0] a0, input int n, input logic fs);
    @(posedge clk_i);
    {cs_low_o, rd_low_o} <= 2'h0;
    fsel_o <= fs;
    data_o <= ~data_o;
    for (int i = 0; i < n; i++) begin
      addr_o <= a0 + ADDR_W'(i);
      repeat (T_CYCLE_CYC) @(posedge clk_i);
      q[i] = bus_i;
    end
    end_cyc();
  endtask

  // One write framed by select and write strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    {cs_low_o, wr_low_o} <= 2'h0;
    {addr_o, fsel_o} <= {a, 1'h0};
    data_o <= d;
    repeat (T_CSL_CYC) @(posedge clk_i);
    end_cyc();
  endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top import host_port_pkg::*;;
  localparam logic [26:0] BASE = 27'h2AB_CDEF;
  localparam logic [31:0] RXS = 32'hC001_0001;
  localparam logic [31:0] TXS = 32'hC002_0002;
  localparam logic [31:0] WRD = 32'hA5A5_0000;
  localparam logic [31:0] M16 = 32'h0000_FFFF;
  localparam logic [31:0] M32 = 32'hFFFF_FFFF;
  typedef struct packed {
    logic b16;
    logic fs;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] e;
  } row_t;
  // Single reads: narrow bus, direct select, address, expected word
  row_t rows [0:6] = '{
    '{1'h0, 1'h0, 7'h0C, {BASE, 5'h03}},
    '{1'h0, 1'h0, 7'h74, RXS},
    '{1'h0, 1'h0, 7'h78, TXS},
    '{1'h0, 1'h0, 7'h70, WRD},
    '{1'h0, 1'h1, 7'h7D, WRD + 32'h0000_0001},
    '{1'h1, 1'h1, 7'h02, WRD + 32'h0000_0002},
    '{1'h1, 1'h0, 7'h15, {BASE, 5'h05}}};
  logic sys_clk_i, nrst_i, cs_l, rd_l, wr_l, fsel, bus16, rx_v, rx_rdy, dlo, dhi, over;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] hd, bus, dout, rx_d, live, rx_sts, tx_sts;
  logic [CSR_IDX_W-1:0] idx;
  logic [26:0] base;
  wr_cmd_t cmd;
  int fail_count = 0;
  int num_checks = 0;

  // Register value follows index; device halves win the bus while enabled
  assign live = {base, idx};
  assign bus = {dhi ? dout[31:16] : hd[31:16], dlo ? dout[15:0] : hd[15:0]};

  initial begin
    sys_clk_i = 1'h0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  sram_like_host_bus_port dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .chip_select_low_i(cs_l), .read_strobe_low_i(rd_l), .write_strobe_low_i(wr_l),
    .addr_i(addr), .fifo_sel_i(fsel), .bus16_i(bus16), .data_i(bus), .data_o(dout),
    .data_lo_oe_o(dlo), .data_hi_oe_o(dhi), .rx_in_valid_i(rx_v), .rx_in_ready_o(rx_rdy),
    .rx_in_data_i(rx_d), .csr_live_i(live), .csr_idx_o(idx), .rx_sts_i(rx_sts),
    .rx_sts_pop_o(), .tx_sts_i(tx_sts), .tx_sts_pop_o(), .rx_data_idx_i(5'h1C),
    .rx_sts_idx_i(5'h1D), .tx_sts_idx_i(5'h1E), .wr_valid_o(), .wr_cmd_o(cmd),
    .burst_over_o(over));

  host_bus_model host (.clk_i(sys_clk_i), .bus_i(bus), .cs_low_o(cs_l), .rd_low_o(rd_l),
    .wr_low_o(wr_l), .addr_o(addr), .fsel_o(fsel), .data_o(hd));

  // Comparison and closing report
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_word({31'h0000_0000, g}, {31'h0000_0000, e});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Push one receive word, bounded wait for acceptance
  task automatic push(input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk_i);
    rx_v <= 1'h1;
    rx_d <= d;
    @(posedge sys_clk_i);
    while (rx_rdy !== 1'h1 && k < 16) begin
      @(posedge sys_clk_i);
      k++;
    end
    rx_v <= 1'h0;
    if (k == 16) begin
      fail_count++;
      end_of_test();
    end
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fail_count++;
    end_of_test();
  end

  initial begin
    logic [ADDR_W-1:0] t;
    logic [31:0] m;
    int n;
    {nrst_i, bus16, rx_v} = 3'h0;
    rx_d = DATA_ZERO;
    base = BASE;
    rx_sts = RXS;
    tx_sts = TXS;
    repeat (4) @(posedge sys_clk_i);
    nrst_i <= 1'h1;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk_bit(dlo | dhi, 1'h0);
    // Fill the receive buffer until it refuses
    for (int i = 0; i < RX_FIFO_DEPTH; i++) begin
      push(WRD + 32'(i));
    end
    @(posedge sys_clk_i);
    rx_v <= 1'h1;
    @(negedge sys_clk_i);
    chk_bit(rx_rdy, 1'h0);
    @(posedge sys_clk_i);
    rx_v <= 1'h0;
    foreach (rows[i]) begin
      @(posedge sys_clk_i);
      bus16 <= rows[i].b16;
      host.burst(rows[i].a, 1, rows[i].fs);
      m = rows[i].b16 ? M16 : M32;
      chk_word(host.q[0] & m, rows[i].e & m);
    end
    // Direct burst past the normal limit drains the buffer, then reads empty
    @(posedge sys_clk_i);
    bus16 <= 1'h0;
    host.burst(7'h58, 10, 1'h1);
    for (int i = 0; i < 10; i++) begin
      chk_word(host.q[i], i < 5 ? WRD + 32'(i + 3) : DATA_ZERO);
    end
    chk_bit(over, 1'h0);
    // Host waits out the settle time after receive reads
    repeat (T_INFO_WAIT_CYC) @(posedge sys_clk_i);
    // Normal bursts at and one past the limit for both widths
    for (int md = 0; md < 2; md++) begin
      for (int k = 0; k < 2; k++) begin
        n = (md == 1 ? BURST_MAX_16 : BURST_MAX_32) + k;
        m = md == 1 ? M16 : M32;
        @(posedge sys_clk_i);
        bus16 <= md[0];
        host.burst(7'h04, n, 1'h0);
        for (int i = 0; i < n; i++) begin
          t = 7'h04 + 7'(i);
          chk_word(host.q[i] & m, {BASE, t[6:2]} & m);
        end
        chk_bit(over, k[0]);
      end
    end
    // Writes on wide and narrow bus
    for (int md = 0; md < 2; md++) begin
      @(posedge sys_clk_i);
      bus16 <= md[0];
      host.wr(7'h15, 32'hDEAD_BEEF);
      @(negedge sys_clk_i);
      chk_word({25'h000_0000, cmd.addr}, 32'h0000_0015);
      chk_word(cmd.data, md == 1 ? 32'h0000_BEEF : 32'hDEAD_BEEF);
    end
    // Register value changes in mid-read; the read start value must return
    @(posedge sys_clk_i);
    bus16 <= 1'h0;
    fork
      host.burst(7'h0C, 1, 1'h0);
      begin
        repeat (4) @(posedge sys_clk_i);
        base <= ~BASE;
      end
    join
    chk_word(host.q[0], {BASE, 5'h03});
    host.burst(7'h0C, 1, 1'h0);
    chk_word(host.q[0], {~BASE, 5'h03});
    end_of_test();
  end
endmodule
